// ---- include/fsw_pkg.sv ----
// Purpose: Shared constants for the flash self-write sequencer and its core-side partner
// Assumes: 25 MHz system clock, special register page at 98h..9Dh
// Notes: Timing counts derive from times in their own units
package fsw_pkg;
  // Register offsets on the core's special register bus
  localparam logic [7:0] FSW_OFS_CTRL = 8'h98;
  localparam logic [7:0] FSW_OFS_UNLOCK = 8'h99;
  localparam logic [7:0] FSW_OFS_ADRL = 8'h9a;
  localparam logic [7:0] FSW_OFS_ADRH = 8'h9b;
  localparam logic [7:0] FSW_OFS_DATL = 8'h9c;
  localparam logic [7:0] FSW_OFS_DATH = 8'h9d;
  // Control register fields
  localparam int FSW_BIT_RD = 0;
  localparam int FSW_BIT_WR = 1;
  localparam int FSW_BIT_WRITE_ENABLE_BIT = 2;
  // Reset values
  localparam logic [7:0] FSW_RST_CTRL = 8'h00;
  localparam logic [7:0] FSW_RST_BYTE = 8'h00;
  // Unlock key bytes
  localparam logic [7:0] FSW_KEY1 = 8'h55;
  localparam logic [7:0] FSW_KEY2 = 8'haa;
  // Geometry
  localparam int FSW_BLK_WORDS = 4;
  localparam int FSW_ERASE_WORDS = 16;
  localparam int FSW_ADDR_W = 11;
  localparam int FSW_WORD_W = 14;
  // Timing
  localparam int FSW_CLK_KHZ = 25000;
  localparam int FSW_ERASE_MS = 4;
  localparam int FSW_PWRT_MS = 64;
  localparam int FSW_ERASE_CYC = FSW_ERASE_MS * FSW_CLK_KHZ;
  localparam int FSW_PWRT_CYC = FSW_PWRT_MS * FSW_CLK_KHZ;
  localparam int FSW_SETUP_CYC = 2;
  // Sequencer states
  typedef enum logic [4:0] {
    FSW_IDLE = 5'h01,
    FSW_SETUP = 5'h02,
    FSW_ERASE = 5'h04,
    FSW_PROG = 5'h08,
    FSW_DONE = 5'h10
  } fsw_state_t;
endpackage

// ---- include/fsw_if.sv ----
// Purpose: Special register bus between core and flash self-write sequencer
// Assumes: One clock, single-cycle writes and combinational reads
// Notes: Core drives the request side, sequencer the answers
`timescale 1ns/1ps
interface fsw_if;
  logic wr_en;
  logic rd_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic core_halt;
  logic slot_squash;
  modport dev (input wr_en, input rd_en, input addr, input wdata, output rdata, output core_halt, output slot_squash);
  modport core (output wr_en, output rd_en, output addr, output wdata, input rdata, input core_halt, input slot_squash);
endinterface

// ---- core/fsw_seq.sv ----
// Purpose: Program flash self-write and self-read sequencer
// Assumes: Flash array is an internal memory; core issues one register access per cycle
// Notes: Erase and program share one halt window of FSW_ERASE_CYC + 1 cycles
// Operation
// (RQ1) Writes commit only as aligned four-word blocks
// (RQ2) Block write erases sixteen words, programs four
// (RQ3) Block address forced to aligned edges
// (RQ4) Core loads address then data before writing
// (RQ5) Unlock 55h, AAh, then set write-start
// (RQ6) Core fills all four buffer words
// (RQ7) Core writes words in ascending order
// (RQ8) Last word triggers erase and programming
// (RQ9) First three words only load buffer
// (RQ10) Two setup cycles after write-start
// (RQ11) Core halted during erase, about 4 ms
// (RQ12) Resume at third instruction after start
// (RQ13) Core repeats blocks for twelve more words; bench writes one block per row and leaves the other twelve erased
// (RQ14) Power-up clears enable, timer blocks writes
// (RQ15) Key and enable both needed for write
// (RQ16) Code protect keeps core access plain
// (RQ17) Write protect blocks only external programming
// (RQ18) Read happens second cycle after read-start
// (RQ19) Key broken by any other access aborts; code resets the key on other writes only, reads leave it
// (RQ20) Write-start clears itself when done
`timescale 1ns/1ps
module fsw_seq #(
  parameter int ERASE_CYC = fsw_pkg::FSW_ERASE_CYC,
  parameter int PWRT_CYC = fsw_pkg::FSW_PWRT_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register bus from the core
  fsw_if.dev bus,
  // Protection and external programming
  input wire logic code_protect,
  input wire logic write_protect,
  input wire logic ext_prog_req,
  output logic ext_access_ok,
  output logic ext_write_ok,
  // Status
  output logic busy
);
  localparam int AW = fsw_pkg::FSW_ADDR_W;
  localparam int WW = fsw_pkg::FSW_WORD_W;
  localparam int DEPTH = 1 << AW;

  logic [WW-1:0] flash_mem [DEPTH];
  logic [WW-1:0] buf_q [fsw_pkg::FSW_BLK_WORDS];
  logic [7:0] adrl_q;
  logic [2:0] adrh_q;
  logic [7:0] datl_q;
  logic [5:0] dath_q;
  logic write_enable_bit_q;
  logic wr_q;
  logic rd_q;
  logic [1:0] key_q;
  logic [1:0] rd_cnt_q;
  logic [31:0] pwrt_q;
  logic [31:0] cnt_q;
  logic [3:0] prog_idx_q;
  logic last_q;
  fsw_pkg::fsw_state_t state_q;
  logic [AW-1:0] addr;
  logic pwrt_run;
  logic wr_ctrl;
  logic start_ok;

  assign addr = {adrh_q, adrl_q};
  assign pwrt_run = pwrt_q != 32'h0;
  assign wr_ctrl = bus.wr_en && bus.addr == fsw_pkg::FSW_OFS_CTRL;
  // Start needs full key, enable bit and expired power-up timer
  assign start_ok = wr_ctrl && bus.wdata[fsw_pkg::FSW_BIT_WR] && key_q == 2'h2 && write_enable_bit_q && !pwrt_run
    && state_q == fsw_pkg::FSW_IDLE; // see (RQ5) see (RQ15) see (RQ14)

  // Power-up timer; writes refused until it expires
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pwrt_q <= PWRT_CYC; // see (RQ14)
    end else if (pwrt_run) begin
      pwrt_q <= pwrt_q - 32'h1;
    end
  end

  // Unlock key tracker: any write other than the next step resets it
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      key_q <= 2'h0;
    end else if (bus.wr_en) begin
      if (bus.addr == fsw_pkg::FSW_OFS_UNLOCK && bus.wdata == fsw_pkg::FSW_KEY1 && key_q == 2'h0) begin
        key_q <= 2'h1; // see (RQ19)
      end else if (bus.addr == fsw_pkg::FSW_OFS_UNLOCK && bus.wdata == fsw_pkg::FSW_KEY2 && key_q == 2'h1) begin
        key_q <= 2'h2;
      end else begin
        key_q <= 2'h0; // see (RQ19)
      end
    end
  end

  // Address registers
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      adrl_q <= fsw_pkg::FSW_RST_BYTE;
      adrh_q <= 3'h0;
    end else if (bus.wr_en && bus.addr == fsw_pkg::FSW_OFS_ADRL) begin
      adrl_q <= bus.wdata;
    end else if (bus.wr_en && bus.addr == fsw_pkg::FSW_OFS_ADRH) begin
      adrh_q <= bus.wdata[2:0];
    end
  end

  // Data registers; a completed read overwrites them
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      datl_q <= fsw_pkg::FSW_RST_BYTE;
      dath_q <= 6'h0;
    end else if (rd_cnt_q == 2'h1) begin
      {dath_q, datl_q} <= flash_mem[addr]; // see (RQ18) see (RQ16)
    end else if (bus.wr_en && bus.addr == fsw_pkg::FSW_OFS_DATL) begin
      datl_q <= bus.wdata;
    end else if (bus.wr_en && bus.addr == fsw_pkg::FSW_OFS_DATH) begin
      dath_q <= bus.wdata[5:0];
    end
  end

  // Control register: enable bit and read-start; write-start is kept by the write sequencer
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      write_enable_bit_q <= 1'b0; // see (RQ14)
      rd_q <= 1'b0;
      rd_cnt_q <= 2'h0;
    end else begin
      if (wr_ctrl) begin
        write_enable_bit_q <= bus.wdata[fsw_pkg::FSW_BIT_WRITE_ENABLE_BIT];
      end
      if (wr_ctrl && bus.wdata[fsw_pkg::FSW_BIT_RD] && rd_cnt_q == 2'h0) begin
        rd_q <= 1'b1;
        rd_cnt_q <= 2'h2; // see (RQ18)
      end else if (rd_cnt_q != 2'h0) begin
        rd_cnt_q <= rd_cnt_q - 2'h1;
        rd_q <= rd_cnt_q != 2'h1;
      end
    end
  end

  // Write sequencer: setup with buffer load, then erase and program for the last word
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_q <= fsw_pkg::FSW_IDLE;
      wr_q <= 1'b0;
      cnt_q <= 32'h0;
      last_q <= 1'b0;
      prog_idx_q <= 4'h0;
    end else begin
      unique case (state_q)
        fsw_pkg::FSW_IDLE: begin
          if (start_ok) begin
            wr_q <= 1'b1;
            last_q <= adrl_q[1:0] == 2'h3; // see (RQ8)
            cnt_q <= 32'(fsw_pkg::FSW_SETUP_CYC - 1);
            state_q <= fsw_pkg::FSW_SETUP; // see (RQ10)
          end
        end
        fsw_pkg::FSW_SETUP: begin
          if (cnt_q != 32'h0) begin
            cnt_q <= cnt_q - 32'h1;
          end else if (last_q) begin
            cnt_q <= 32'(ERASE_CYC - 1);
            prog_idx_q <= 4'h0;
            state_q <= fsw_pkg::FSW_ERASE; // see (RQ2)
          end else begin
            state_q <= fsw_pkg::FSW_DONE; // see (RQ9)
          end
        end
        fsw_pkg::FSW_ERASE: begin
          prog_idx_q <= prog_idx_q + 4'h1;
          if (cnt_q != 32'h0) begin
            cnt_q <= cnt_q - 32'h1;
          end else begin
            state_q <= fsw_pkg::FSW_PROG; // see (RQ11)
          end
        end
        fsw_pkg::FSW_PROG: begin
          state_q <= fsw_pkg::FSW_DONE;
        end
        fsw_pkg::FSW_DONE: begin
          wr_q <= 1'b0; // see (RQ20)
          state_q <= fsw_pkg::FSW_IDLE;
        end
        default: begin
          state_q <= fsw_pkg::FSW_IDLE;
        end
      endcase
    end
  end

  // Buffer load at the end of setup, indexed by the low address bits
  always_ff @(posedge clk_sys) begin
    if (state_q == fsw_pkg::FSW_SETUP && cnt_q == 32'h0) begin
      buf_q[adrl_q[1:0]] <= {dath_q, datl_q}; // see (RQ7) see (RQ1)
    end
  end

  // Flash array: erase the aligned 16-word row, then program the aligned 4-word block
  always_ff @(posedge clk_sys) begin
    if (state_q == fsw_pkg::FSW_ERASE && prog_idx_q < 4'(fsw_pkg::FSW_ERASE_WORDS - 1)) begin
      flash_mem[{addr[AW-1:4], prog_idx_q}] <= {WW{1'b1}}; // see (RQ2) see (RQ3)
    end else if (state_q == fsw_pkg::FSW_ERASE && prog_idx_q == 4'(fsw_pkg::FSW_ERASE_WORDS - 1)) begin
      flash_mem[{addr[AW-1:4], prog_idx_q}] <= {WW{1'b1}};
    end else if (state_q == fsw_pkg::FSW_PROG) begin
      for (int i = 0; i < fsw_pkg::FSW_BLK_WORDS; i++) begin
        flash_mem[{addr[AW-1:2], 2'(i)}] <= buf_q[i]; // see (RQ1) see (RQ3) see (RQ17)
      end
    end
  end

  // Read mux for the special registers; unlock register reads as zero
  always_comb begin
    bus.rdata = 8'h00;
    unique case (bus.addr)
      fsw_pkg::FSW_OFS_CTRL: bus.rdata = {5'h0, write_enable_bit_q, wr_q, rd_q};
      fsw_pkg::FSW_OFS_ADRL: bus.rdata = adrl_q;
      fsw_pkg::FSW_OFS_ADRH: bus.rdata = {5'h0, adrh_q};
      fsw_pkg::FSW_OFS_DATL: bus.rdata = datl_q;
      fsw_pkg::FSW_OFS_DATH: bus.rdata = {2'h0, dath_q};
      default: bus.rdata = 8'h00;
    endcase
  end

  // Halt the core through erase and program only; squash the read slot
  assign bus.core_halt = state_q == fsw_pkg::FSW_ERASE || state_q == fsw_pkg::FSW_PROG; // see (RQ11) see (RQ12)
  assign bus.slot_squash = rd_cnt_q == 2'h1; // see (RQ18)
  assign busy = wr_q;
  // External access off under code protect; external writes off under write protect
  assign ext_access_ok = ext_prog_req && !code_protect; // see (RQ16)
  assign ext_write_ok = ext_prog_req && !code_protect && !write_protect; // see (RQ17)
endmodule

// ---- core/fsw_core_end.sv ----
// Purpose: Core-side partner issuing self-write and self-read sequences
// Assumes: User side presents one word at a time with its address
// Notes: Each access takes one cycle; halt freezes the sequence
`timescale 1ns/1ps
module fsw_core_end (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // User request
  input wire logic req_write,
  input wire logic req_read,
  input wire logic [10:0] req_addr,
  input wire logic [13:0] req_data,
  output logic req_ready,
  output logic [13:0] rd_word,
  output logic rd_valid,
  // Register bus to the sequencer
  fsw_if.core bus
);
  logic [3:0] step_q;
  logic op_wr_q;
  logic [10:0] a_q;
  logic [13:0] d_q;
  logic [7:0] lo_q;
  logic [13:0] rd_word_q;
  logic rd_valid_q;

  assign req_ready = step_q == 4'h0;
  assign rd_word = rd_word_q;
  assign rd_valid = rd_valid_q;

  // Step through address, data, enable, key, start, two setup slots and a halt wait
  // The last slot holds until the halt is over, so nothing reaches the bus while halted
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      step_q <= 4'h0;
      op_wr_q <= 1'b0;
      a_q <= 11'h0;
      d_q <= 14'h0;
      lo_q <= 8'h00;
      rd_word_q <= 14'h0;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= 1'b0;
      if (step_q == 4'h0) begin
        if (req_write || req_read) begin
          op_wr_q <= req_write;
          a_q <= req_addr; // see (RQ4) see (RQ7) see (RQ6)
          d_q <= req_data;
          step_q <= 4'h1;
        end
      end else if (!bus.core_halt) begin
        if (!op_wr_q && step_q == 4'h6) begin
          lo_q <= bus.rdata;
        end
        if (!op_wr_q && step_q == 4'h7) begin
          rd_word_q <= {bus.rdata[5:0], lo_q};
          rd_valid_q <= 1'b1;
          step_q <= 4'h0;
        end else if (op_wr_q && step_q == 4'hc) begin
          step_q <= 4'h0; // see (RQ12)
        end else begin
          step_q <= step_q + 4'h1;
        end
      end
    end
  end

  // Register access for each step
  always_comb begin
    bus.wr_en = 1'b0;
    bus.rd_en = 1'b0;
    bus.addr = 8'h00;
    bus.wdata = 8'h00;
    unique case (step_q)
      4'h1: begin
        bus.wr_en = 1'b1;
        bus.addr = fsw_pkg::FSW_OFS_ADRH;
        bus.wdata = {5'h0, a_q[10:8]};
      end
      4'h2: begin
        bus.wr_en = 1'b1;
        bus.addr = fsw_pkg::FSW_OFS_ADRL;
        bus.wdata = a_q[7:0];
      end
      4'h3: begin
        bus.wr_en = 1'b1;
        bus.addr = op_wr_q ? fsw_pkg::FSW_OFS_DATL : fsw_pkg::FSW_OFS_CTRL;
        bus.wdata = op_wr_q ? d_q[7:0] : 8'h01;
      end
      4'h4: begin
        bus.wr_en = op_wr_q;
        bus.addr = fsw_pkg::FSW_OFS_DATH;
        bus.wdata = {2'h0, d_q[13:8]};
      end
      4'h6: begin
        bus.wr_en = op_wr_q;
        bus.rd_en = !op_wr_q;
        bus.addr = op_wr_q ? fsw_pkg::FSW_OFS_CTRL : fsw_pkg::FSW_OFS_DATL;
        bus.wdata = 8'h04;
      end
      4'h7: begin
        bus.wr_en = op_wr_q;
        bus.rd_en = !op_wr_q;
        bus.addr = op_wr_q ? fsw_pkg::FSW_OFS_UNLOCK : fsw_pkg::FSW_OFS_DATH;
        bus.wdata = fsw_pkg::FSW_KEY1; // see (RQ5)
      end
      4'h8: begin
        bus.wr_en = 1'b1;
        bus.addr = fsw_pkg::FSW_OFS_UNLOCK;
        bus.wdata = fsw_pkg::FSW_KEY2;
      end
      4'h9: begin
        bus.wr_en = 1'b1;
        bus.addr = fsw_pkg::FSW_OFS_CTRL;
        bus.wdata = 8'h06; // see (RQ10) two idle slots, then a slot that waits out the halt
      end
      default: begin
        bus.wr_en = 1'b0;
      end
    endcase
  end
endmodule

// ---- sim/fsw_assertions.sv ----
// Purpose: Watches the register bus between core end and sequencer
// Assumes: Key bytes count per write, not per cycle
// Notes: Start qualification is rebuilt here from observed writes
`timescale 1ns/1ps
module fsw_checker #(
  parameter int ERASE_CYC = 20,
  parameter int PWRT_CYC = 10
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register bus
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic core_halt,
  input wire logic slot_squash
);
  logic k1_q, k2_q, write_enable_bit_q, ctrl_w, start_w;
  logic [1:0] adrl_q;
  int up_q, since_q, halt_q;
  // Write-start that the sequencer must accept
  assign ctrl_w = wr_en && addr == fsw_pkg::FSW_OFS_CTRL;
  assign start_w = ctrl_w && wdata[fsw_pkg::FSW_BIT_WR] && k2_q && write_enable_bit_q
    && up_q > PWRT_CYC + 2 && !core_halt;
  // Key progress, broken by any other write
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      k1_q <= 1'b0;
      k2_q <= 1'b0;
    end else if (wr_en) begin
      k1_q <= addr == fsw_pkg::FSW_OFS_UNLOCK && wdata == fsw_pkg::FSW_KEY1;
      k2_q <= k1_q && addr == fsw_pkg::FSW_OFS_UNLOCK && wdata == fsw_pkg::FSW_KEY2;
    end
  end
  // Shadow of enable bit and word index
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      write_enable_bit_q <= 1'b0;
      adrl_q <= 2'h0;
    end else begin
      if (ctrl_w) write_enable_bit_q <= wdata[fsw_pkg::FSW_BIT_WRITE_ENABLE_BIT];
      if (wr_en && addr == fsw_pkg::FSW_OFS_ADRL) adrl_q <= wdata[1:0];
    end
  end
  // Cycles since reset, since last block start, inside the halt
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      up_q <= 0;
      since_q <= 1000;
      halt_q <= 0;
    end else begin
      up_q <= (up_q > PWRT_CYC + 2) ? up_q : up_q + 1;
      since_q <= (start_w && adrl_q == 2'h3) ? 0 : (since_q < 1000 ? since_q + 1 : since_q);
      halt_q <= core_halt ? halt_q + 1 : 0;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence rd_start_s;
    ctrl_w && wdata[fsw_pkg::FSW_BIT_RD];
  endsequence
  sequence squash_pulse_s;
    slot_squash ##1 !slot_squash;
  endsequence
  squash_after_read_a: assert property (rd_start_s |-> ##2 squash_pulse_s)
    else $error("ignored slot missing after read start");
  squash_cause_a: assert property (slot_squash |-> $past(ctrl_w && wdata[fsw_pkg::FSW_BIT_RD], 2))
    else $error("ignored slot without read start");
  halt_after_last_a: assert property (start_w && adrl_q == 2'h3 |-> ##[1:4] core_halt)
    else $error("last word did not halt the core");
  no_halt_buffer_a: assert property (start_w && adrl_q != 2'h3 |=> !core_halt [*6])
    else $error("buffer word halted the core");
  halt_cause_a: assert property ($rose(core_halt) |-> since_q <= 5)
    else $error("halt without a qualified start");
  halt_length_a: assert property ($fell(core_halt) |-> halt_q >= ERASE_CYC && halt_q <= ERASE_CYC + 2)
    else $error("halt length wrong");
  halt_bounded_a: assert property (core_halt |-> halt_q <= ERASE_CYC + 2)
    else $error("halt too long");
  no_bus_in_halt_a: assert property (core_halt |-> !wr_en && !rd_en)
    else $error("core used the bus while halted");
  unlock_reads_zero_a: assert property (addr == fsw_pkg::FSW_OFS_UNLOCK |-> rdata == 8'h00)
    else $error("unlock register did not read as zero");
  start_after_key_a: assert property (ctrl_w && wdata[fsw_pkg::FSW_BIT_WR] |-> k2_q)
    else $error("write start not preceded by key");
endmodule

// ---- sim/testbench.sv ----
// Purpose: Joins core end and sequencer, checks block writes, reads and lockouts
// Assumes: Shortened erase and power-up counts
// Notes: A second sequencer is driven straight from the bench
`timescale 1ns/1ps
module testbench;
  localparam int ERASE = 20;
  localparam int PWRT = 10;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic req_write = 1'b0;
  logic req_read = 1'b0;
  logic [10:0] req_addr = 11'h000;
  logic [13:0] req_data = 14'h0000;
  logic cp = 1'b0;
  logic wp = 1'b0;
  logic ep = 1'b0;
  logic req_ready, rd_valid, busy, busy2, acc_ok, wr_ok;
  logic [13:0] rd_word;
  logic [15:0] wq [$];
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  int halt_n = 0;
  fsw_if bus ();
  fsw_if bus2 ();
  fsw_seq #(.ERASE_CYC(ERASE), .PWRT_CYC(PWRT)) fsw_seq_inst (.clk_sys(clk_sys), .reset_n(reset_n), .bus(bus),
    .code_protect(cp), .write_protect(wp), .ext_prog_req(ep), .ext_access_ok(acc_ok), .ext_write_ok(wr_ok), .busy(busy));
  fsw_seq #(.ERASE_CYC(ERASE), .PWRT_CYC(PWRT)) fsw_seq_inst_b (.clk_sys(clk_sys), .reset_n(reset_n), .bus(bus2),
    .code_protect(cp), .write_protect(wp), .ext_prog_req(ep), .ext_access_ok(), .ext_write_ok(), .busy(busy2));
  fsw_core_end fsw_core_end_inst (.clk_sys(clk_sys), .reset_n(reset_n), .req_write(req_write), .req_read(req_read),
    .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready), .rd_word(rd_word), .rd_valid(rd_valid), .bus(bus));
  fsw_checker #(.ERASE_CYC(ERASE), .PWRT_CYC(PWRT)) fsw_checker_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .wr_en(bus.wr_en), .rd_en(bus.rd_en), .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata),
    .core_halt(bus.core_halt), .slot_squash(bus.slot_squash));
  // Clock, bus monitor, halt counter and hang guard
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (bus.wr_en === 1'b1) wq.push_back({bus.addr, bus.wdata});
    if (bus.core_halt === 1'b1) halt_n++;
    cyc++;
    if (cyc > 5000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  function automatic logic [7:0] last_wr(input logic [7:0] a);
    last_wr = 8'hxx;
    foreach (wq[i]) if (wq[i][15:8] === a) last_wr = wq[i][7:0];
  endfunction
  // Direct write and read on the second sequencer
  task automatic bw(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus2.wr_en <= 1'b1;
    bus2.addr <= a;
    bus2.wdata <= d;
  endtask
  task automatic rd2(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    bus2.rd_en <= 1'b1;
    bus2.addr <= a;
    #1;
    check(bus2.rdata === e, "register read back");
  endtask
  // Key, optional stray write, start; count busy cycles
  task automatic t_seq(input logic brk, input logic [7:0] c, input int exp_n);
    int n;
    bw(fsw_pkg::FSW_OFS_UNLOCK, fsw_pkg::FSW_KEY1);
    if (brk) bw(fsw_pkg::FSW_OFS_DATL, 8'h00);
    bw(fsw_pkg::FSW_OFS_UNLOCK, fsw_pkg::FSW_KEY2);
    bw(fsw_pkg::FSW_OFS_CTRL, c);
    @(posedge clk_sys);
    bus2.wr_en <= 1'b0;
    n = 0;
    repeat (10) begin
      #1;
      if (busy2 === 1'b1) n++;
      @(posedge clk_sys);
    end
    check(n == exp_n, "write start gating");
  endtask
  task automatic t_lock();
    rd2(fsw_pkg::FSW_OFS_CTRL, fsw_pkg::FSW_RST_CTRL);
    rd2(fsw_pkg::FSW_OFS_ADRL, fsw_pkg::FSW_RST_BYTE);
    bw(fsw_pkg::FSW_OFS_CTRL, 8'h04);
    t_seq(1'b0, 8'h06, 0);
    bw(fsw_pkg::FSW_OFS_CTRL, 8'h00);
    t_seq(1'b0, 8'h02, 0);
    bw(fsw_pkg::FSW_OFS_CTRL, 8'h04);
    t_seq(1'b1, 8'h06, 0);
    t_seq(1'b0, 8'h06, 3);
    rd2(fsw_pkg::FSW_OFS_CTRL, 8'h04);
  endtask
  // Core end user side
  task automatic wait_ready();
    int i;
    i = 0;
    #1;
    while (req_ready !== 1'b1 && i < 300) begin
      @(posedge clk_sys);
      #1;
      i++;
    end
    check(req_ready === 1'b1, "core end never ready");
  endtask
  task automatic get_word(input logic [10:0] a, output logic [13:0] d);
    int i;
    wait_ready();
    @(posedge clk_sys);
    req_read <= 1'b1;
    req_addr <= a;
    @(posedge clk_sys);
    req_read <= 1'b0;
    i = 0;
    #1;
    while (rd_valid !== 1'b1 && i < 50) begin
      @(posedge clk_sys);
      #1;
      i++;
    end
    check(rd_valid === 1'b1, "read answer missing");
    d = rd_word;
  endtask
  task automatic t_block(input logic [10:0] base, input logic [13:0] seed);
    logic [13:0] d;
    logic [10:0] a;
    int j;
    for (int w = 0; w < 4; w++) begin
      a = base + 11'(w);
      d = seed + 14'(w);
      wq.delete();
      halt_n = 0;
      wait_ready();
      @(posedge clk_sys);
      req_write <= 1'b1;
      req_addr <= a;
      req_data <= d;
      @(posedge clk_sys);
      req_write <= 1'b0;
      wait_ready();
      j = -1;
      foreach (wq[i]) if (wq[i][15:8] === fsw_pkg::FSW_OFS_CTRL && wq[i][1] === 1'b1) j = i;
      check(j >= 2 && wq[j-2] === {fsw_pkg::FSW_OFS_UNLOCK, fsw_pkg::FSW_KEY1}
        && wq[j-1] === {fsw_pkg::FSW_OFS_UNLOCK, fsw_pkg::FSW_KEY2}, "key then start");
      check(last_wr(fsw_pkg::FSW_OFS_ADRL) === a[7:0] && last_wr(fsw_pkg::FSW_OFS_ADRH) === {5'h00, a[10:8]}
        && last_wr(fsw_pkg::FSW_OFS_DATL) === d[7:0] && last_wr(fsw_pkg::FSW_OFS_DATH) === {2'h0, d[13:8]},
        "address or data bytes");
      check(w == 3 ? (halt_n >= ERASE && halt_n <= ERASE + 2) : halt_n == 0, "halt length");
    end
    for (int w = 0; w < 4; w++) begin
      get_word(base + 11'(w), d);
      check(d === seed + 14'(w), "word read back");
    end
    get_word(base + 11'h004, d);
    check(d === 14'h3fff, "erased row word");
  endtask
  task automatic t_protect();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      {cp, wp, ep} <= 3'(i);
      @(posedge clk_sys);
      #1;
      check(acc_ok === (ep & ~cp) && wr_ok === (ep & ~cp & ~wp), "external gating");
    end
  endtask
  // Main sequence
  initial begin
    bus2.wr_en = 1'b0;
    bus2.rd_en = 1'b0;
    bus2.addr = 8'h00;
    bus2.wdata = 8'h00;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_lock();
    t_protect();
    t_block(11'h120, 14'h2b3d);
    @(posedge clk_sys);
    {cp, wp, ep} <= 3'h0;
    t_block(11'h3f0, 14'h1a5c);
    end_of_test();
  end
endmodule
